// File: rac_master.sv
`timescale 1ns/100ps
`default_nettype none
module rac_master (
   // bus
   input  wire logic clk_sys,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   int half = 4;
   // clock stands high outside frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic hp;
      repeat (half) @(posedge clk_sys);
   endtask
   // scl may be low on entry: release data before raising it
   task automatic start;
      sda_low <= 1'b0;
      hp;
      scl <= 1'b1;
      hp;
      sda_low <= 1'b1;
      hp;
      scl <= 1'b0;
      hp;
   endtask
   task automatic stop;
      sda_low <= 1'b1;
      hp;
      scl <= 1'b1;
      hp;
      sda_low <= 1'b0;
      hp;
   endtask
   task automatic bit_x(input logic b, output logic r);
      sda_low <= !b;
      hp;
      scl <= 1'b1;
      hp;
      r = sda;
      scl <= 1'b0;
      hp;
   endtask
   // w of 8'hff releases data for a read; ackb low acks it
   task automatic xfer(input logic [7:0] w, input logic ackb,
                       output logic [7:0] r, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bit_x(w[i], r[i]);
      bit_x(ackb, a);
      ack = !a;
   endtask
endmodule
`default_nettype wire

// File: rac_mem_if.sv
`timescale 1ns/100ps
`default_nettype none
interface rac_mem_if;
   logic       wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   modport ctrl (output wr_en, output wr_addr, output wr_data,
                 output rd_addr, input rd_data);
   modport mem  (input wr_en, input wr_addr, input wr_data,
                 input rd_addr, output rd_data);
endinterface
`default_nettype wire

// File: rac_pkg.sv
package rac_pkg;
   localparam logic [6:0] RAC_DEV_ADDR    = 7'h18;
   localparam logic [6:0] RAC_GCALL_ADDR  = 7'h00;
   localparam int         RAC_BYTE_BITS   = 8;
   localparam logic [2:0] RAC_LAST_BIT    = 3'h7;
   localparam logic [7:0] RAC_PAGE_REG    = 8'h00;
   localparam logic [7:0] RAC_PAGE_RESET  = 8'h00;
   localparam logic [7:0] RAC_PTR_RESET   = 8'h00;
   localparam logic [7:0] RAC_PTR_STEP    = 8'h01;
   localparam int         RAC_CLK_HZ      = 25000000;
   localparam int         RAC_FAST_HZ     = 400000;
   // shortest scl half period in system cycles, rounded down
   localparam int         RAC_HALF_CYC    = RAC_CLK_HZ / (2 * RAC_FAST_HZ);

   typedef enum logic [2:0] {
      RAC_IDLE,
      RAC_ADDR,
      RAC_ADDR_ACK,
      RAC_WR_BYTE,
      RAC_WR_ACK,
      RAC_RD_BYTE,
      RAC_RD_ACK
   } rac_state_t;

   function automatic logic [7:0] rac_next_ptr(input logic [7:0] p);
      rac_next_ptr = p + RAC_PTR_STEP;
   endfunction
endpackage

// File: rac_regmem.sv
`timescale 1ns/100ps
`default_nettype none
module rac_regmem
   import rac_pkg::*;
(
   // clock
   input  wire logic clk_sys,
   input  wire logic clk_en,
   // port
   rac_mem_if.mem    mp
);
   logic [7:0] mem_q [0:255];
   logic [7:0] rd_q;

   always_ff @(posedge clk_sys) begin
      if (clk_en && mp.wr_en) begin
         mem_q[mp.wr_addr] <= mp.wr_data;
      end
   end

   // registered read port
   always_ff @(posedge clk_sys) begin
      if (clk_en) begin
         rd_q <= mem_q[mp.rd_addr];
      end
   end

   assign mp.rd_data = rd_q;
endmodule
`default_nettype wire

// File: rac_slave.sv
// Behaviour
// - seven-bit addressing, up to 400 kHz clock
// - answer one fixed address and the general call address
// - slave only, never makes START/STOP
// - pins only pulled low or released
// - eight-bit units, each then one ack
// - sample data on clock rising edge
// - data edges during clock high: START/STOP
// - pull data low on accepted byte ack
// - high data in ack means not-ack
// - START while busy restarts address phase
// - general call address also acknowledged
// - write bytes auto-increment register pointer
// - acked read sends next register
// - registers eight bits, D7 is MSB
// - drive data on reads, acks on writes
// - idle until START, ignore data
`timescale 1ns/100ps
`default_nettype none
module rac_slave
   import rac_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   input  wire logic       clk_en,
   // two-wire bus
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   output logic            scl_out,
   output logic            scl_oe,
   // status
   output logic            busy,
   output logic [7:0]      page_sel,
   output logic            gcall_seen
);
   rac_mem_if mif ();

   rac_regmem u_mem (
      .clk_sys (clk_sys),
      .clk_en  (clk_en),
      .mp      (mif.mem)
   );

   // two-flop synchronisers, then a third stage for edge detection
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic       scl_prev_q;
   logic       sda_prev_q;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_prev_q <= 1'h1;
         sda_prev_q <= 1'h1;
      end else if (clk_en) begin
         scl_sync_q <= {scl_sync_q[0], scl_in};
         sda_sync_q <= {sda_sync_q[0], sda_in};
         scl_prev_q <= scl_sync_q[1];
         sda_prev_q <= sda_sync_q[1];
      end
   end

   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   assign scl_s     = scl_sync_q[1];
   assign sda_s     = sda_sync_q[1];
   assign scl_rise  = scl_s && !scl_prev_q;
   assign scl_fall  = !scl_s && scl_prev_q;
   assign start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s;
   assign stop_det  = scl_s && scl_prev_q && !sda_prev_q && sda_s;

   rac_state_t state_q;
   logic [2:0] bit_q;
   logic       full_q;
   logic [7:0] shift_q;
   logic       rw_q;
   logic       ptr_loaded_q;
   logic [7:0] ptr_q;
   logic [7:0] page_q;
   logic       ack_drive_q;
   logic       tx_drive_q;
   logic       mem_wr_q;
   logic [7:0] mem_wdata_q;
   logic [7:0] mem_waddr_q;
   logic       gcall_q;
   logic       busy_q;
   logic [7:0] tx_q;

   logic [7:0] rx_byte;
   logic       addr_hit;
   logic       gcall_hit;
   logic       byte_end;
   logic       count_en;
   assign rx_byte   = {shift_q[6:0], sda_s};
   assign addr_hit  = (shift_q[7:1] == RAC_DEV_ADDR);
   assign gcall_hit = (shift_q[7:1] == RAC_GCALL_ADDR);
   // eighth bit taken and its clock low again: ack slot opens
   assign byte_end  = scl_fall && full_q;
   // only byte phases count clocks; ack clocks stay out of the count
   assign count_en  = (state_q == RAC_ADDR) || (state_q == RAC_WR_BYTE) ||
                      (state_q == RAC_RD_BYTE);

   // main protocol sequencer; clock edges come only from the master
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_q      <= RAC_IDLE;
         bit_q        <= 3'h0;
         full_q       <= 1'h0;
         shift_q      <= 8'h00;
         rw_q         <= 1'h0;
         ptr_loaded_q <= 1'h0;
         busy_q       <= 1'h0;
         gcall_q      <= 1'h0;
      end else if (clk_en) begin
         if (start_det) begin
            state_q      <= RAC_ADDR;
            bit_q        <= 3'h0;
            full_q       <= 1'h0;
            busy_q       <= 1'h1;
            ptr_loaded_q <= 1'h0;
         end else if (stop_det) begin
            state_q <= RAC_IDLE;
            busy_q  <= 1'h0;
            full_q  <= 1'h0;
         end else begin
            if (count_en && scl_rise) begin
               bit_q  <= bit_q + 3'h1;
               full_q <= (bit_q == RAC_LAST_BIT);
            end else if (byte_end) begin
               full_q <= 1'h0;
            end
            unique case (state_q)
               RAC_IDLE: begin
                  bit_q <= 3'h0;
               end
               RAC_ADDR: begin
                  if (scl_rise) begin
                     shift_q <= rx_byte;
                  end
                  if (byte_end) begin
                     // address plus direction complete
                     if (addr_hit || gcall_hit) begin
                        state_q <= RAC_ADDR_ACK;
                        rw_q    <= shift_q[0] && addr_hit;
                        gcall_q <= gcall_hit;
                     end else begin
                        state_q <= RAC_IDLE;
                     end
                  end
               end
               RAC_ADDR_ACK: begin
                  if (scl_fall) begin
                     state_q <= rw_q ? RAC_RD_BYTE : RAC_WR_BYTE;
                     bit_q   <= 3'h0;
                  end
               end
               RAC_WR_BYTE: begin
                  if (scl_rise) begin
                     shift_q <= rx_byte;
                  end
                  if (byte_end) begin
                     state_q <= RAC_WR_ACK;
                  end
               end
               RAC_WR_ACK: begin
                  if (scl_rise) begin
                     ptr_loaded_q <= 1'h1;
                  end
                  if (scl_fall) begin
                     state_q <= RAC_WR_BYTE;
                     bit_q   <= 3'h0;
                  end
               end
               RAC_RD_BYTE: begin
                  if (byte_end) begin
                     state_q <= RAC_RD_ACK;
                  end
               end
               RAC_RD_ACK: begin
                  if (scl_rise) begin
                     // high data in ack ends the read
                     state_q <= sda_s ? RAC_IDLE : RAC_RD_BYTE;
                     bit_q   <= 3'h0;
                  end
               end
               // spare enum code: fall back to waiting for a start
               default: begin
                  state_q <= RAC_IDLE;
               end
            endcase
         end
      end
   end

   // pointer, page and register writes
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         ptr_q       <= RAC_PTR_RESET;
         page_q      <= RAC_PAGE_RESET;
         mem_wr_q    <= 1'h0;
         mem_waddr_q <= 8'h00;
         mem_wdata_q <= 8'h00;
      end else if (clk_en) begin
         mem_wr_q <= 1'h0;
         if (state_q == RAC_WR_ACK && scl_rise && !gcall_q) begin
            if (!ptr_loaded_q) begin
               ptr_q <= shift_q;
            end else begin
               if (ptr_q == RAC_PAGE_REG) begin
                  page_q <= shift_q;
               end else begin
                  mem_wr_q    <= 1'h1;
                  mem_waddr_q <= ptr_q;
                  mem_wdata_q <= shift_q;
               end
               ptr_q <= rac_next_ptr(ptr_q);
            end
         end else if (state_q == RAC_RD_ACK && scl_rise && !sda_s) begin
            ptr_q <= rac_next_ptr(ptr_q);
         end
      end
   end

   assign mif.wr_en   = mem_wr_q;
   assign mif.wr_addr = mem_waddr_q;
   assign mif.wr_data = mem_wdata_q;
   assign mif.rd_addr = ptr_q;

   // read shifter: load at byte start, shift msb first on falling edges
   logic rd_load;
   assign rd_load = (state_q == RAC_RD_BYTE) && bit_q == 3'h0 &&
                    !full_q && !scl_s;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         tx_q <= 8'hff;
      end else if (clk_en) begin
         if (rd_load) begin
            tx_q <= (ptr_q == RAC_PAGE_REG) ? page_q : mif.rd_data;
         end else if (state_q == RAC_RD_BYTE && scl_fall) begin
            tx_q <= {tx_q[6:0], 1'h1};
         end
      end
   end

   // open-drain drive; only low is ever driven, data changes with scl low
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         ack_drive_q <= 1'h0;
         tx_drive_q  <= 1'h0;
      end else if (clk_en) begin
         ack_drive_q <= (state_q == RAC_ADDR_ACK ||
                         state_q == RAC_WR_ACK) && !start_det;
         // data moves while the clock is low; held through high while still in RAC_RD_BYTE, else released at once
         if (!scl_s) begin
            tx_drive_q <= (state_q == RAC_RD_BYTE) && !tx_q[7];
         end else if (state_q != RAC_RD_BYTE) begin
            tx_drive_q <= 1'h0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         sda_oe     <= 1'h0;
         busy       <= 1'h0;
         page_sel   <= RAC_PAGE_RESET;
         gcall_seen <= 1'h0;
      end else if (clk_en) begin
         sda_oe     <= ack_drive_q || tx_drive_q;
         busy       <= busy_q;
         page_sel   <= page_q;
         gcall_seen <= gcall_q;
      end
   end

   // scl is never pulled and no bus condition is ever generated
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         sda_out <= 1'h0;
         scl_out <= 1'h0;
         scl_oe  <= 1'h0;
      end else begin
         sda_out <= 1'h0;
         scl_out <= 1'h0;
         scl_oe  <= 1'h0;
      end
   end
endmodule
`default_nettype wire

// File: rac_slave_chk.sv
`timescale 1ns/100ps
`default_nettype none
module rac_slave_chk (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   input  wire logic       clk_en,
   // bus
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic       sda_out,
   input  wire logic       sda_oe,
   input  wire logic       scl_oe,
   // status
   input  wire logic       busy,
   input  wire logic [7:0] page_sel,
   input  wire logic       gcall_seen
);
   default clocking @(posedge clk_sys); endclocking
   // frozen cycles see pin activity that the block must ignore
   default disable iff (!reset_n || !clk_en);
   sequence bus_start;
      scl_in && $past(scl_in) && $fell(sda_in);
   endsequence
   chk_scl_free: assert property (!scl_oe)
      else $error("clock line driven by slave");
   chk_sda_open: assert property (sda_oe |-> !sda_out)
      else $error("data line driven high");
   chk_oe_moves: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data drive moved while clock high");
   chk_idle_quiet: assert property (!busy |-> !sda_oe)
      else $error("data driven while bus idle");
   chk_start_busy: assert property (bus_start |-> ##[1:8] busy)
      else $error("start not seen");
   chk_stop_idle: assert property (scl_in && $past(scl_in)
      && $rose(sda_in) |-> ##[1:8] !busy) else $error("stop not seen");
   chk_page_busy: assert property ($changed(page_sel) |-> busy)
      else $error("page moved outside a transfer");
   chk_gcall_busy: assert property ($rose(gcall_seen) |-> busy)
      else $error("general call flag outside a transfer");
   cov_gcall: cover property ($rose(gcall_seen));
   cov_page: cover property ($changed(page_sel));
   cov_drive: cover property ($rose(sda_oe));
endmodule
bind rac_slave rac_slave_chk i_rac_slave_chk (.clk_sys(clk_sys),
   .reset_n(reset_n), .clk_en(clk_en), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .scl_oe(scl_oe), .busy(busy),
   .page_sel(page_sel), .gcall_seen(gcall_seen));
`default_nettype wire

// File: rac_slave_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
   err_total++; $display("wrong value %s exp %h got %h", n, e, a); end end
module rac_slave_tb
   import rac_pkg::*;
;
   logic       clk_sys = 1'b0;
   logic       reset_n = 1'b0;
   logic       clk_en = 1'b1;
   logic       scl_m, sda_m_low, sda_oe, scl_oe, sda_out, scl_out;
   logic       busy, gcall_seen;
   logic [7:0] page_sel, rd;
   logic       ack;
   int         err_total = 0;
   int         comparisons = 0;
   // open-drain wires with pull-ups
   wire logic  scl_in = scl_m & !(scl_oe & !scl_out);
   wire logic  sda_in = !(sda_m_low | (sda_oe & !sda_out));

   always #20 clk_sys = ~clk_sys;

   rac_slave i_rac_slave (.clk_sys(clk_sys), .reset_n(reset_n),
      .clk_en(clk_en), .scl_in(scl_in), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out),
      .scl_oe(scl_oe), .busy(busy), .page_sel(page_sel),
      .gcall_seen(gcall_seen));
   rac_master i_rac_master (.clk_sys(clk_sys), .sda(sda_in),
      .scl(scl_m), .sda_low(sda_m_low));

   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic wait_busy(input logic v);
      for (int i = 0; i < 40 && busy !== v; i++) @(posedge clk_sys);
      `CHK("busy", v, busy)
      if (busy !== v) end_of_test;
   endtask
   task automatic wr(input logic [7:0] b, input logic e);
      i_rac_master.xfer(b, 1'b1, rd, ack);
      `CHK("ack", e, ack)
   endtask
   task automatic t_reset;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      `CHK("sda_oe", 1'b0, sda_oe)
      `CHK("busy", 1'b0, busy)
      `CHK("page_sel", RAC_PAGE_RESET, page_sel)
      `CHK("gcall_seen", 1'b0, gcall_seen)
      `CHK("scl_oe", 1'b0, scl_oe)
      `CHK("scl_out", 1'b0, scl_out)
      `CHK("sda_out", 1'b0, sda_out)
   endtask
   task automatic t_write;
      i_rac_master.start();
      wr({RAC_DEV_ADDR, 1'b0}, 1'b1);
      wr(RAC_PAGE_REG, 1'b1);
      wr(8'h05, 1'b1);
      `CHK("busy", 1'b1, busy)
      wr(8'ha5, 1'b1);
      wr(8'h3c, 1'b1);
      i_rac_master.stop();
      wait_busy(1'b0);
      `CHK("page_sel", 8'h05, page_sel)
   endtask
   task automatic t_gcall;
      i_rac_master.start();
      wr({RAC_GCALL_ADDR, 1'b0}, 1'b1);
      wr(8'h77, 1'b1);
      `CHK("gcall_seen", 1'b1, gcall_seen)
      i_rac_master.stop();
      wait_busy(1'b0);
   endtask
   // slow bus clock, repeated start, two reads
   task automatic t_read;
      i_rac_master.half = 16;
      i_rac_master.start();
      wr({RAC_DEV_ADDR, 1'b0}, 1'b1);
      wr(8'h01, 1'b1);
      i_rac_master.start();
      wr({RAC_DEV_ADDR, 1'b1}, 1'b1);
      `CHK("gcall_seen", 1'b0, gcall_seen)
      i_rac_master.xfer(8'hff, 1'b0, rd, ack);
      `CHK("rd", 8'ha5, rd)
      i_rac_master.xfer(8'hff, 1'b1, rd, ack);
      `CHK("rd", 8'h3c, rd)
      i_rac_master.stop();
      wait_busy(1'b0);
      i_rac_master.half = 4;
   endtask
   // foreign address: no ack, later bytes ignored
   task automatic t_refuse;
      i_rac_master.start();
      wr({RAC_DEV_ADDR ^ 7'h01, 1'b0}, 1'b0);
      wr(8'h00, 1'b0);
      wr(8'h07, 1'b0);
      i_rac_master.stop();
      wait_busy(1'b0);
      `CHK("page_sel", 8'h05, page_sel)
   endtask

   // clock enable low: a whole frame passes unseen
   task automatic t_freeze;
      clk_en <= 1'b0;
      i_rac_master.start();
      wr({RAC_DEV_ADDR, 1'b0}, 1'b0);
      wr(RAC_PAGE_REG, 1'b0);
      wr(8'h09, 1'b0);
      i_rac_master.stop();
      `CHK("busy", 1'b0, busy)
      clk_en <= 1'b1;
      repeat (8) @(posedge clk_sys);
      `CHK("busy", 1'b0, busy)
      `CHK("page_sel", 8'h05, page_sel)
   endtask

   initial begin
      t_reset;
      t_write;
      t_gcall;
      t_read;
      t_refuse;
      t_freeze;
      end_of_test;
   end
endmodule
`default_nettype wire
